// *** design/restart_interlock_muting_override.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Trip (interlock enabled), power-up, muting fault outside override lock outputs off.
// - Locked: red and yellow lamps lit.
// - Locked: yellow only while field clear.
// - Press-release within bounds unlocks to ON.
// - Muting error flashes; only then override accepted.
// - Press, release, press within window.
// - Override lasts while input held.
// - Override limited: long limit, sequence-muting short.
// - Valid muting lets input release early.
// - Final release: valid muting resumes, else off.
// - Beam interruption without valid muting switches outputs off, except in override.
// - Interruption turns status lamp green to red.
// - Interlock enabled and disabled modes supported.
module restart_interlock_muting_override #(
  parameter longint unsigned HOLD_MIN  = restart_pkg::HOLD_MIN_CYC,
  parameter longint unsigned HOLD_MAX  = restart_pkg::HOLD_MAX_CYC,
  parameter longint unsigned SEQ_WIN   = restart_pkg::SEQ_WIN_CYC,
  parameter longint unsigned OVR_LONG  = restart_pkg::OVR_LONG_CYC,
  parameter longint unsigned OVR_SHORT = restart_pkg::OVR_SHORT_CYC,
  parameter longint unsigned FLASH     = restart_pkg::FLASH_CYC
) (
  input  wire logic                clk,             // 100 MHz clock
  input  wire logic                rst_n,           // Synchronous reset, low active
  input  wire logic                psel,            // APB select
  input  wire logic                penable,         // APB enable
  input  wire logic                pwrite,          // APB direction
  input  wire logic [11:0]         paddr,           // APB byte address
  input  wire logic [31:0]         pwdata,          // APB write data
  output logic                     pready,          // APB ready
  output logic [31:0]              prdata,          // APB read data
  output logic                     pslverr,         // APB error
  input  wire logic                restart_cmd,     // Restart button or controller output
  input  wire logic                field_clear,     // All active beams unobstructed
  input  wire logic                muting_valid,    // Valid muting condition
  input  wire logic                muting_fault,    // Muting timeout or fault event
  output logic                     safety_switching_output, // Safety outputs enable
  output restart_pkg::lamps_t      lamps,           // Status lamps
  output logic                     irq              // Level interrupt
);

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  logic [1:0]  ctrl_reg;
  logic [3:0]  irq_st_reg;
  logic [3:0]  irq_st_next;
  logic [3:0]  irq_mk_reg;
  logic [3:0]  events;
  restart_pkg::state_t state_reg;
  restart_pkg::state_t state_next;
  logic        acc;
  logic        known;

  assign acc     = psel && penable;
  assign pready  = 1'b1;
  assign known   = (paddr == restart_pkg::CTRL_OFS) || (paddr == restart_pkg::STATE_OFS)
                || (paddr == restart_pkg::IRQ_ST_OFS) || (paddr == restart_pkg::IRQ_MK_OFS);
  assign pslverr = acc && !known;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_reg <= restart_pkg::CTRL_RESET;
    else if (acc && pwrite && paddr == restart_pkg::CTRL_OFS)
      ctrl_reg <= pwdata[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_mk_reg <= restart_pkg::IRQ_MK_RESET;
    else if (acc && pwrite && paddr == restart_pkg::IRQ_MK_OFS)
      irq_mk_reg <= pwdata[3:0];
  end

  // Set wins over a write-one clear in the same cycle.
  always_comb
  begin
    irq_st_next = irq_st_reg;
    if (acc && pwrite && paddr == restart_pkg::IRQ_ST_OFS)
      irq_st_next = irq_st_next & ~pwdata[3:0];
    irq_st_next = irq_st_next | events;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_st_reg <= 4'h0;
    else
      irq_st_reg <= irq_st_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_st_next & irq_mk_reg);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      case (paddr)
        restart_pkg::CTRL_OFS:   prdata <= {30'h0, ctrl_reg};
        restart_pkg::STATE_OFS:  prdata <= {27'h0, state_reg};
        restart_pkg::IRQ_ST_OFS: prdata <= {28'h0, irq_st_reg};
        restart_pkg::IRQ_MK_OFS: prdata <= {28'h0, irq_mk_reg};
        default:                 prdata <= 32'h0;
      endcase
  end

  // ------------------------------------------------------------------
  // Restart input timing
  // ------------------------------------------------------------------
  logic        cmd_d;
  logic        cmd_rise;
  logic        cmd_fall;
  logic [31:0] hold_cnt;
  logic [31:0] seq_cnt;
  logic [1:0]  seq_step;
  logic [63:0] ovr_cnt;
  logic [31:0] flash_cnt;
  logic        flash;
  logic        good_press;
  logic        ovr_limit;
  logic        ovr_start;

  assign cmd_rise = restart_cmd && !cmd_d;
  assign cmd_fall = !restart_cmd && cmd_d;
  // Release only counts with hold time inside the bounds.
  assign good_press = cmd_fall && (64'(hold_cnt) >= HOLD_MIN) && (64'(hold_cnt) <= HOLD_MAX);
  assign ovr_limit  = ctrl_reg[restart_pkg::CTRL_SEQ2_BIT] ?
                      (ovr_cnt >= OVR_SHORT) : (ovr_cnt >= OVR_LONG);
  // Second press within the window after the first.
  assign ovr_start  = (state_reg == restart_pkg::ST_MUTERR) && seq_step == 2'd2 && cmd_rise;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmd_d <= 1'b0;
    else
      cmd_d <= restart_cmd;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hold_cnt <= 32'h0;
    else if (cmd_rise)
      hold_cnt <= 32'h1; // The rising sample is the first high cycle.
    else if (restart_cmd && hold_cnt != 32'hFFFF_FFFF)
      hold_cnt <= hold_cnt + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || state_reg != restart_pkg::ST_MUTERR)
    begin
      seq_step <= 2'd0;
      seq_cnt  <= 32'h0;
    end
    else if (seq_step != 2'd0 && 64'(seq_cnt) >= SEQ_WIN)
    begin
      seq_step <= 2'd0;
      seq_cnt  <= 32'h0;
    end
    else
    begin
      if (seq_step != 2'd0)
        seq_cnt <= seq_cnt + 32'h1;
      if (seq_step == 2'd0 && cmd_rise)
      begin
        seq_step <= 2'd1;
        seq_cnt  <= 32'h0;
      end
      else if (seq_step == 2'd1 && cmd_fall)
        seq_step <= 2'd2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || state_reg != restart_pkg::ST_OVR)
      ovr_cnt <= 64'h0;
    else
      ovr_cnt <= ovr_cnt + 64'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || 64'(flash_cnt) + 64'd1 >= FLASH)
    begin
      flash_cnt <= 32'h0;
      flash     <= rst_n ? !flash : 1'b0;
    end
    else
      flash_cnt <= flash_cnt + 32'h1;
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      restart_pkg::ST_LOCKED:
        if (muting_fault)
          state_next = restart_pkg::ST_MUTERR;
        else if (good_press && field_clear)
          state_next = restart_pkg::ST_RUN;
      restart_pkg::ST_RUN:
        if (muting_fault)
          state_next = restart_pkg::ST_MUTERR;
        else if (!field_clear && !muting_valid)
          state_next = ctrl_reg[restart_pkg::CTRL_IL_EN_BIT] ?
                       restart_pkg::ST_LOCKED : restart_pkg::ST_BLOCKED;
      restart_pkg::ST_BLOCKED:
        if (muting_fault)
          state_next = restart_pkg::ST_MUTERR;
        else if (field_clear)
          state_next = restart_pkg::ST_RUN;
      restart_pkg::ST_MUTERR:
        if (ovr_start)
          state_next = restart_pkg::ST_OVR;
        else if (good_press && field_clear)
          state_next = restart_pkg::ST_RUN;
      restart_pkg::ST_OVR:
        if (ovr_limit)
          state_next = restart_pkg::ST_MUTERR;
        else if (!restart_cmd && muting_valid)
          state_next = restart_pkg::ST_RUN;
        else if (!restart_cmd)
          state_next = restart_pkg::ST_MUTERR;
      default:
        state_next = restart_pkg::ST_LOCKED;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_reg <= restart_pkg::ST_LOCKED;
    else
      state_reg <= state_next;
  end

  always_comb
  begin
    events = 4'h0;
    events[restart_pkg::EV_TRIP]   = state_reg == restart_pkg::ST_RUN
                                  && (state_next == restart_pkg::ST_LOCKED
                                   || state_next == restart_pkg::ST_BLOCKED);
    events[restart_pkg::EV_UNLOCK] = state_reg != restart_pkg::ST_RUN
                                  && state_next == restart_pkg::ST_RUN;
    events[restart_pkg::EV_MUTERR] = state_reg != restart_pkg::ST_MUTERR
                                  && state_next == restart_pkg::ST_MUTERR;
    events[restart_pkg::EV_OVR]    = ovr_start;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      safety_switching_output <= 1'b0;
      lamps                   <= '0;
    end
    else
    begin
      safety_switching_output <= state_next == restart_pkg::ST_RUN
                              || state_next == restart_pkg::ST_OVR;
      lamps.green  <= state_next == restart_pkg::ST_RUN
                   || state_next == restart_pkg::ST_OVR;
      lamps.red    <= !(state_next == restart_pkg::ST_RUN
                     || state_next == restart_pkg::ST_OVR);
      lamps.yellow <= (state_next == restart_pkg::ST_LOCKED
                    || state_next == restart_pkg::ST_MUTERR) && field_clear;
      lamps.muting <= state_next == restart_pkg::ST_MUTERR ? flash
                   : (state_next == restart_pkg::ST_OVR
                   || (state_next == restart_pkg::ST_RUN && muting_valid));
    end
  end

endmodule

// *** design/restart_pkg.sv ***
package restart_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned HOLD_MIN_MS     = 150;
  localparam int unsigned HOLD_MAX_MS     = 4000;
  localparam int unsigned SEQ_WINDOW_MS   = 4000;
  localparam int unsigned OVR_LONG_S      = 120;
  localparam int unsigned OVR_SHORT_S     = 5;
  localparam int unsigned FLASH_MS        = 250;
  localparam longint unsigned HOLD_MIN_CYC  = longint'(HOLD_MIN_MS) * CLK_HZ / 1000;
  localparam longint unsigned HOLD_MAX_CYC  = longint'(HOLD_MAX_MS) * CLK_HZ / 1000;
  localparam longint unsigned SEQ_WIN_CYC   = longint'(SEQ_WINDOW_MS) * CLK_HZ / 1000;
  localparam longint unsigned OVR_LONG_CYC  = longint'(OVR_LONG_S) * CLK_HZ;
  localparam longint unsigned OVR_SHORT_CYC = longint'(OVR_SHORT_S) * CLK_HZ;
  localparam longint unsigned FLASH_CYC     = longint'(FLASH_MS) * CLK_HZ / 1000;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATE_OFS  = 12'h004;
  localparam logic [11:0] IRQ_ST_OFS = 12'h008;
  localparam logic [11:0] IRQ_MK_OFS = 12'h00C;
  localparam int unsigned CTRL_IL_EN_BIT = 0;
  localparam int unsigned CTRL_SEQ2_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h1;
  localparam logic [3:0]  IRQ_MK_RESET   = 4'h0;
  localparam int unsigned EV_TRIP   = 0;
  localparam int unsigned EV_UNLOCK = 1;
  localparam int unsigned EV_MUTERR = 2;
  localparam int unsigned EV_OVR    = 3;

  typedef enum logic [4:0] {
    ST_LOCKED  = 5'h01,
    ST_RUN     = 5'h02,
    ST_MUTERR  = 5'h04,
    ST_OVR     = 5'h08,
    ST_BLOCKED = 5'h10
  } state_t;

  typedef struct packed {
    logic red;
    logic yellow;
    logic green;
    logic muting;
  } lamps_t;

endpackage

// *** bench/restart_button_model.sv ***
`timescale 1ns/1ps
module restart_button_model (
  input  wire logic clk,         // Bench clock
  output logic      restart_cmd  // Sourcing switched command line
);
  initial restart_cmd = 1'b0;
  // Press for hold cycles, release, then stay idle for gap cycles.
  task automatic push(input int hold, input int gap);
    @(posedge clk);
    restart_cmd <= 1'b1;
    repeat (hold) @(posedge clk);
    restart_cmd <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// *** bench/restart_interlock_muting_override_props.sv ***
`timescale 1ns/1ps
module restart_interlock_muting_override_props #(
  parameter longint unsigned HOLD_MIN = 15,
  parameter longint unsigned HOLD_MAX = 400,
  parameter longint unsigned OVR_LONG = 1000
) (
  input wire logic          clk,                     // Clock
  input wire logic          rst_n,                   // Reset
  input wire logic          psel,                    // Select
  input wire logic          penable,                 // Enable
  input wire logic [11:0]   paddr,                   // Address
  input wire logic          pready,                  // Ready
  input wire logic          pslverr,                 // Error
  input wire logic          restart_cmd,             // Restart input
  input wire logic          field_clear,             // Field clear
  input wire logic          muting_valid,            // Muting valid
  input wire logic          safety_switching_output, // Outputs
  input restart_pkg::lamps_t lamps                   // Lamps
);
  logic [31:0] hold_cnt;
  logic [31:0] on_cnt;
  // Counts the samples of one press, and of outputs on with a blocked field.
  always_ff @(posedge clk)
    hold_cnt <= (!rst_n || !restart_cmd) ? 32'h0 : hold_cnt + 32'h1;
  always_ff @(posedge clk)
    on_cnt <= (!rst_n || !safety_switching_output || field_clear || muting_valid)
              ? 32'h0 : on_cnt + 32'h1;
  sequence release_s;
    $fell(restart_cmd) && !safety_switching_output;
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  off_in_reset_a: assert property (disable iff (1'b0) !rst_n |=> !safety_switching_output)
    else $error("outputs on after reset");
  red_means_off_a: assert property (lamps.red |-> !safety_switching_output)
    else $error("red lamp with outputs on");
  yellow_clear_a: assert property (lamps.yellow |-> $past(field_clear))
    else $error("yellow lamp with blocked field");
  unlock_a: assert property (release_s ##0 (hold_cnt >= HOLD_MIN && hold_cnt <= HOLD_MAX
    && field_clear && lamps.red && lamps.yellow && !muting_valid) |=> ##[0:2] safety_switching_output)
    else $error("valid press did not unlock");
  bad_press_a: assert property (release_s ##0 (hold_cnt < HOLD_MIN || hold_cnt > HOLD_MAX)
    |=> !safety_switching_output [*3])
    else $error("bad press unlocked");
  ovr_limit_a: assert property (on_cnt <= OVR_LONG + 4)
    else $error("override beyond limit");
  trip_off_a: assert property (safety_switching_output && !field_clear && !muting_valid
    && !restart_cmd && !$past(restart_cmd) && !$past(restart_cmd, 2) |=> !safety_switching_output)
    else $error("outputs stayed on after trip");
  green_on_a: assert property (safety_switching_output |-> lamps.green && !lamps.red)
    else $error("lamp does not follow outputs");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("ready low in access");
  unmapped_a: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
    else $error("no error on unmapped address");
endmodule
bind restart_interlock_muting_override restart_interlock_muting_override_props #(
  .HOLD_MIN(HOLD_MIN), .HOLD_MAX(HOLD_MAX), .OVR_LONG(OVR_LONG)) u_props (.clk, .rst_n,
  .psel, .penable, .paddr, .pready, .pslverr, .restart_cmd, .field_clear, .muting_valid,
  .safety_switching_output, .lamps);

// *** bench/restart_interlock_muting_override_tb_top.sv ***
`timescale 1ns/1ps
module restart_interlock_muting_override_tb_top;
  logic clk, rst_n, psel, penable, pwrite, field_clear, muting_valid, muting_fault;
  logic pready, pslverr, restart_cmd, out, irq, se, a;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  restart_pkg::lamps_t lamps;
  int err_total, compares;
  restart_interlock_muting_override #(.HOLD_MIN(15), .HOLD_MAX(400),
    .OVR_LONG(1000), .OVR_SHORT(100), .FLASH(8)) u_dut (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .restart_cmd, .field_clear,
    .muting_valid, .muting_fault, .safety_switching_output(out), .lamps, .irq);
  restart_button_model u_btn (.clk, .restart_cmd);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_out(input logic v);
    repeat (6) if (out !== v) @(posedge clk);
    chk(out, v);
  endtask
  task automatic fault;
    muting_fault <= 1'b1;
    @(posedge clk);
    muting_fault <= 1'b0;
    field_clear <= 1'b0;
    wait_out(1'b0);
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h1);
    chk({out, lamps}, 5'h0C);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk(se, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk(se, 1'b1);
    chk(rd, 32'h0);
  endtask
  task automatic t_unlock;
    u_btn.push(5, 20);
    chk(out, 1'b0);
    u_btn.push(500, 20);
    chk(out, 1'b0);
    u_btn.push(50, 0);
    wait_out(1'b1);
    apb(1'b1, 12'h00C, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask
  task automatic t_trip;
    field_clear <= 1'b0;
    wait_out(1'b0);
    repeat (2) @(posedge clk);
    chk(lamps, 4'h8);
    u_btn.push(50, 5);
    chk(out, 1'b0);
    field_clear <= 1'b1;
    repeat (3) @(posedge clk);
    chk(lamps, 4'hC);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[0], 1'b1);
    u_btn.push(50, 0);
    wait_out(1'b1);
  endtask
  task automatic t_override;
    fault;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h4);
    a = lamps.muting;
    repeat (8) @(posedge clk);
    chk(lamps.muting, !a);
    u_btn.push(20, 10);
    chk(out, 1'b0);
    fork
      u_btn.push(300, 0);
      begin repeat (100) @(posedge clk); chk(out, 1'b1); end
    join
    wait_out(1'b0);
    u_btn.push(20, 10);
    fork
      u_btn.push(30, 0);
      begin repeat (20) @(posedge clk); muting_valid <= 1'b1; end
    join
    repeat (10) @(posedge clk);
    chk({out, lamps.muting}, 2'h3);
    field_clear <= 1'b1;
    muting_valid <= 1'b0;
    fault;
    u_btn.push(20, 10);
    fork
      u_btn.push(1200, 5);
      begin repeat (1050) @(posedge clk); chk(out, 1'b0); end
    join
    apb(1'b1, 12'h000, 32'h3);
    u_btn.push(20, 10);
    fork
      u_btn.push(300, 5);
      begin repeat (50) @(posedge clk); chk(out, 1'b1); repeat (70) @(posedge clk);
        chk(out, 1'b0); end
    join
  endtask
  task automatic t_disabled;
    field_clear <= 1'b1;
    u_btn.push(50, 0);
    wait_out(1'b1);
    apb(1'b1, 12'h000, 32'h0);
    field_clear <= 1'b0;
    wait_out(1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h10);
    field_clear <= 1'b1;
    wait_out(1'b1);
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, muting_valid, muting_fault} = '0;
    field_clear = 1'b1;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_unlock;
    t_trip;
    t_override;
    t_disabled;
    wrap_up;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up;
  end
endmodule
